// ---- scr_regs.vh ----
`ifndef SCR_REGS_VH
`define SCR_REGS_VH
`define SCR_ADDR_CTRL 8'h00
`define SCR_ADDR_SWING 8'h01
`define SCR_ADDR_PERF1 8'h03
`define SCR_ADDR_GAIN 8'h25
`define SCR_ADDR_DRIVE 8'h26
`define SCR_ADDR_FORMAT 8'h3D
`define SCR_ADDR_PATHI 8'h3F
`define SCR_ADDR_PATLO 8'h40
`define SCR_ADDR_CLKOUT 8'h41
`define SCR_ADDR_LATENCY 8'h42
`define SCR_ADDR_PDN 8'h43
`define SCR_ADDR_PERF2 8'h4A
`define SCR_ADDR_PEDESTAL 8'hBF
`define SCR_ADDR_OFSCTRL 8'hCF
`define SCR_ADDR_LOWRATE 8'hDB
`define SCR_RST_VAL 8'h00
`define SCR_BIT_READBACK 0
`define SCR_BIT_SWRESET 1
`define SCR_BIT_GLOBAL_PDN 6
`define SCR_BIT_STANDBY 2
`define SCR_WORD_BITS 16
`define SCR_SYS_CLK_MHZ 25
`define SCR_RST_MAX_NS 1000
`define SCR_RST_MAX_CYC ((`SCR_RST_MAX_NS * `SCR_SYS_CLK_MHZ) / 1000)
`endif

// ---- scr_sync.v ----
`timescale 1ns/1ps
module scr_sync #(
   parameter W = 3
) (
   input wire sys_clk_i,
   input wire rst_i,
   input wire [W-1:0] async_i,
   output reg [W-1:0] sync_o
);
   reg [W-1:0] meta_r;
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_r <= {W{1'b1}};
         sync_o <= {W{1'b1}};
      end else begin
         meta_r <= async_i;
         sync_o <= meta_r;
      end
   end
endmodule // scr_sync

// ---- scr_serial_config.v ----
// Behaviour
// - Data bit sampled on shift clock falling edge while enable is low.
// - Every sixteenth falling edge commits address then data; leftovers ignored.
// - After reset the shared pin shows over-range until readback enabled.
// - Readback enable is bit zero of address zero, beside software reset.
// - In readback mode only address zero accepts writes.
// - Writing readback enable zero restores writes and over-range on pin.
// - Address zero reads back as nothing in readback mode.
// - Readback shifts addressed register out, most significant bit first.
// - Reset pulse over 1 us may briefly select parallel configuration.
// - One write updates every field of a register at once, except address zero: only readback enable is kept.
`timescale 1ns/1ps
`include "scr_regs.vh"
module scr_serial_config #(
   parameter NREG = 15,
   parameter RST_MAX_CYC = `SCR_RST_MAX_CYC
) (
   input wire sys_clk_i,
   input wire rst_i,
   input wire shift_clk_i,
   input wire serial_enable_n_i,
   input wire shift_data_in_i,
   input wire overrange_i,
   output reg overrange_or_readback_pin_o,
   output reg parallel_cfg_mode_o,
   output reg [8*NREG-1:0] reg_bank_o,
   output wire global_power_down_o,
   output wire standby_ctrl_o
);
   localparam [7:0] CTRL_IDX = 8'h00;

   // Address table, one entry per bank slot; slot 14 and above give SCR_ADDR_LOWRATE
   function [7:0] addr_of;
      input integer i;
      begin
         case (i)
            0: addr_of = `SCR_ADDR_CTRL;
            1: addr_of = `SCR_ADDR_SWING;
            2: addr_of = `SCR_ADDR_PERF1;
            3: addr_of = `SCR_ADDR_GAIN;
            4: addr_of = `SCR_ADDR_DRIVE;
            5: addr_of = `SCR_ADDR_FORMAT;
            6: addr_of = `SCR_ADDR_PATHI;
            7: addr_of = `SCR_ADDR_PATLO;
            8: addr_of = `SCR_ADDR_CLKOUT;
            9: addr_of = `SCR_ADDR_LATENCY;
            10: addr_of = `SCR_ADDR_PDN;
            11: addr_of = `SCR_ADDR_PERF2;
            12: addr_of = `SCR_ADDR_PEDESTAL;
            13: addr_of = `SCR_ADDR_OFSCTRL;
            default: addr_of = `SCR_ADDR_LOWRATE;
         endcase
      end
   endfunction

   function [7:0] read_of;
      input [7:0] a;
      input [8*NREG-1:0] bank;
      integer k;
      begin
         read_of = 8'h00;
         for (k = 1; k < NREG; k = k + 1)
            if (addr_of(k) == a)
               read_of = bank[8*k +: 8];
      end
   endfunction

   // Write gate for one bank slot; address zero always stays open so
   // that readback mode can be left again
   function wr_ok;
      input integer slot;
      input rb;
      begin
         wr_ok = (slot == 0) || !rb;
      end
   endfunction

   // Shift clock, enable and data share one synchroniser so that their
   // relative timing survives the crossing
   wire [2:0] sync_w;
   scr_sync #(
      .W(3)
   ) u_sync (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .async_i({shift_clk_i, serial_enable_n_i, shift_data_in_i}),
      .sync_o(sync_w)
   );
   wire sclk_s = sync_w[2];
   wire sen_n_s = sync_w[1];
   wire shift_data_in_s = sync_w[0];

   reg sclk_d_r;
   reg [3:0] bit_cnt_r;
   reg [14:0] shift_r;
   reg [7:0] rd_shift_r;
   reg sw_reset_r;
   wire ovr_n_sync_w;
   wire fall_w = sclk_d_r & ~sclk_s & ~sen_n_s;
   wire readback_w = reg_bank_o[`SCR_BIT_READBACK];
   wire [15:0] word_w = {shift_r, shift_data_in_s};
   integer j;

   // One address comparator per slot, shared by every commit
   wire [NREG-1:0] hit_w;
   genvar g;
   generate
      for (g = 0; g < NREG; g = g + 1) begin : g_hit
         assign hit_w[g] = (addr_of(g) == word_w[15:8]);
      end
   endgenerate

   // Readback shifter: load as the address completes, then one bit
   // per fall through the data half
   reg [7:0] rd_nxt;
   always @* begin
      rd_nxt = rd_shift_r;
      if (fall_w) begin
         if (bit_cnt_r == 4'h7) begin
            rd_nxt = read_of(word_w[7:0], reg_bank_o);
         end else if (bit_cnt_r[3]) begin
            rd_nxt = {rd_shift_r[6:0], 1'b0};
         end
      end
   end

   assign global_power_down_o = reg_bank_o[8*10 + `SCR_BIT_GLOBAL_PDN];
   assign standby_ctrl_o = reg_bank_o[8*9 + `SCR_BIT_STANDBY];

   // A software reset clears the bank one clock after its write; a
   // commit in that same clock still lands, since the later
   // assignment wins
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sclk_d_r <= 1'b0;
         bit_cnt_r <= 4'h0;
         shift_r <= 15'h0000;
         rd_shift_r <= 8'h00;
         sw_reset_r <= 1'b0;
         reg_bank_o <= {NREG{`SCR_RST_VAL}};
      end else begin
         sclk_d_r <= sclk_s;
         sw_reset_r <= 1'b0;
         rd_shift_r <= rd_nxt;
         if (sw_reset_r) begin
            reg_bank_o <= {NREG{`SCR_RST_VAL}};
         end
         if (sen_n_s) begin
            bit_cnt_r <= 4'h0;
         end else if (fall_w) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
            shift_r <= word_w[14:0];
            if (bit_cnt_r == 4'hF) begin
               // Whole byte lands in one go, except at address zero, where only the readback bit is kept
               for (j = 0; j < NREG; j = j + 1) begin
                  if (hit_w[j]) begin
                     if (j == CTRL_IDX) begin
                        reg_bank_o[7:0] <= {7'h00,
                           word_w[`SCR_BIT_READBACK]};
                        sw_reset_r <= word_w[`SCR_BIT_SWRESET];
                     end else if (wr_ok(j, readback_w)) begin
                        reg_bank_o[8*j +: 8] <= word_w[7:0];
                     end
                  end
               end
            end
         end
      end
   end

   // Over-range goes in inverted: the synchroniser resets to ones, so
   // the pin starts low instead of flagging a false over-range
   scr_sync #(
      .W(1)
   ) u_sync_ovr (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .async_i(~overrange_i),
      .sync_o(ovr_n_sync_w)
   );

   // Outside the data half the pin rests low in readback mode, so an
   // early sample reads a clean zero rather than over-range
   reg pin_nxt;
   always @* begin
      pin_nxt = ~ovr_n_sync_w;
      if (readback_w) begin
         pin_nxt = 1'b0;
         if (!sen_n_s && bit_cnt_r[3]) begin
            pin_nxt = rd_shift_r[7];
         end
      end
   end

   // Readback bit leaves on the rising edge, stable at the falling edge
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         overrange_or_readback_pin_o <= 1'b0;
      end else begin
         overrange_or_readback_pin_o <= pin_nxt;
      end
   end

   // Reset pin history for pulse-width measurement; it stays out of the
   // async reset since it must keep counting while the pin is high.
   // Only the flag is modelled: it stands while an over-long pulse lasts.
   reg [RST_MAX_CYC-1:0] rst_hist_r;
   always @(posedge sys_clk_i) begin
      rst_hist_r <= {rst_hist_r[RST_MAX_CYC-2:0], rst_i};
      parallel_cfg_mode_o <= rst_i & (&rst_hist_r);
   end
endmodule // scr_serial_config

// ---- scr_chk_assertions.sv ----
`timescale 1ns/1ps
module scr_chk #(
   parameter NREG = 15
) (
   input wire sys_clk_i,
   input wire rst_i,
   input wire overrange_i,
   input wire serial_enable_n_i,
   input wire overrange_or_readback_pin_o,
   input wire parallel_cfg_mode_o,
   input wire [8*NREG-1:0] reg_bank_o,
   input wire global_power_down_o,
   input wire standby_ctrl_o
);
   wire on = reg_bank_o[0];
   wire pin = overrange_or_readback_pin_o;
   reg [4:0] stab_r;
   reg [7:0] idle_r;
   // Histories cover synchroniser latency before a level can be judged
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         stab_r <= 5'h00;
         idle_r <= 8'h00;
      end else begin
         stab_r <= {stab_r[3:0], !(on || $changed(overrange_i))};
         idle_r <= {idle_r[6:0], serial_enable_n_i};
      end
   end
   default clocking dc @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   par_off_a: assert property (
      $past(!rst_i) |-> !parallel_cfg_mode_o) else $error("par");
   pdn_tie_a: assert property (global_power_down_o == reg_bank_o[86])
      else $error("pdn");
   standby_ctrl_tie_a: assert property (standby_ctrl_o == reg_bank_o[74])
      else $error("standby_ctrl");
   ctrl_zero_a: assert property (reg_bank_o[7:1] == 7'h00)
      else $error("ctrl");
   ovr_pass_a: assert property (stab_r == 5'h1F |-> pin == overrange_i)
      else $error("ovr");
   wr_block_a: assert property (on && $past(on) |-> $stable(reg_bank_o[8*NREG-1:8]))
      else $error("blocked write landed");
   idle_hold_a: assert property (idle_r == 8'hFF |=> $stable(reg_bank_o))
      else $error("idle write");
   idle_low_a: assert property (idle_r == 8'hFF && on |-> !pin)
      else $error("pin");
endmodule // scr_chk
bind scr_serial_config scr_chk #(.NREG(NREG)) chk_u (.sys_clk_i, .rst_i,
   .overrange_i, .serial_enable_n_i, .overrange_or_readback_pin_o,
   .parallel_cfg_mode_o, .reg_bank_o, .global_power_down_o, .standby_ctrl_o);

// ---- scr_ctl.sv ----
`timescale 1ns/1ps
module scr_ctl (
   input wire sys_clk_i,
   input wire pin_i,
   output reg sck_o = 1'b0,
   output reg en_n_o = 1'b1,
   output reg dat_o = 1'b0
);
   // Half period of four clocks gives 320 ns per bit
   task frame(input [47:0] w, input integer n, output [7:0] rd);
      integer i;
      begin
         rd = 8'h00;
         en_n_o = 1'b0;
         repeat (4) @(negedge sys_clk_i);
         for (i = 0; i < n; i = i + 1) begin
            repeat (4) @(negedge sys_clk_i);
            sck_o = 1'b1;
            repeat (2) @(negedge sys_clk_i);
            // Data moves mid-high so it holds across the previous fall
            dat_o = w[47-i];
            repeat (2) @(negedge sys_clk_i);
            if (i % 16 > 7)
               rd = {rd[6:0], pin_i};
            sck_o = 1'b0;
         end
         repeat (2) @(negedge sys_clk_i);
         // Released line shows the inverse, never a stale good bit
         dat_o = ~dat_o;
         repeat (2) @(negedge sys_clk_i);
         en_n_o = 1'b1;
         repeat (8) @(negedge sys_clk_i);
      end
   endtask
endmodule // scr_ctl

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   reg sys_clk_i = 1'b0;
   reg rst_i = 1'b1; // Serial mode: reset pulsed, never tied
   reg ovr = 1'b0;
   wire sck, en_n, dat, pin, par, pdn, standby_ctrl;
   wire [119:0] bank;
   reg [7:0] rd;
   integer miscompares = 0;
   integer compares = 0;
   always #20 sys_clk_i = ~sys_clk_i;
   scr_serial_config dut_u (.sys_clk_i, .rst_i, .shift_clk_i(sck),
      .serial_enable_n_i(en_n), .shift_data_in_i(dat), .overrange_i(ovr),
      .overrange_or_readback_pin_o(pin), .parallel_cfg_mode_o(par),
      .reg_bank_o(bank), .global_power_down_o(pdn), .standby_ctrl_o(standby_ctrl));
   scr_ctl ctl_u (.sys_clk_i, .pin_i(pin), .sck_o(sck), .en_n_o(en_n),
      .dat_o(dat));
   task chk(input [7:0] got, input [7:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      ctl_u.frame({a, d, 32'h0}, 16, rd);
   endtask
   // Data 01 keeps readback on when address zero is named
   task rdb(input [7:0] a, input [7:0] e);
      begin
         ctl_u.frame({a, 8'h01, 32'h0}, 16, rd);
         chk(rd, e);
      end
   endtask
   task wrap_up;
      begin
         $display("compares %0d miscompares %0d", compares, miscompares);
         if (miscompares == 0 && compares > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   initial begin
      #400000;
      miscompares = miscompares + 1;
      wrap_up;
   end
   initial begin
      repeat (8) @(negedge sys_clk_i); // Supplies settled at 0
      rst_i = 1'b0;
      repeat (4) @(negedge sys_clk_i);
      ovr = 1'b1;
      repeat (8) @(negedge sys_clk_i);
      chk({7'h0, pin}, 8'h01);
      ctl_u.frame({16'h25A5, 16'h4340, 16'h26FF}, 37, rd);
      chk(bank[31:24], 8'hA5);
      chk(bank[39:32], 8'h00);
      chk({6'h0, par, pdn}, 8'h01);
      wr(8'h00, 8'h01);
      wr(8'h26, 8'hFF);
      chk(bank[39:32], 8'h00);
      rdb(8'h43, 8'h40);
      rdb(8'h25, 8'hA5);
      rdb(8'h00, 8'h00);
      rdb(8'h02, 8'h00);
      wr(8'h00, 8'h00);
      chk({7'h0, pin}, 8'h01);
      wr(8'h42, 8'h04);
      chk({7'h0, standby_ctrl}, 8'h01);
      wr(8'h00, 8'h02);
      chk(bank[79:72], 8'h00);
      // Over-long mid-run reset raises the parallel flag while held
      rst_i = 1'b1;
      repeat (30) @(negedge sys_clk_i);
      chk({7'h0, par}, 8'h01);
      rst_i = 1'b0;
      repeat (4) @(negedge sys_clk_i);
      chk({7'h0, par}, 8'h00);
      chk({7'h0, pin}, 8'h01);
      wrap_up;
   end
endmodule // tb_top
